// ===== shared/crc_pkg.sv
package crc_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_POLY = 8'h08;
  localparam logic [7:0] OFS_SEED = 8'h0C;
  localparam logic [7:0] OFS_XOR = 8'h10;
  localparam logic [7:0] OFS_GATE = 8'h14;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CTRL_RESET_BIT = 0;
  localparam int CTRL_INPUT_BIT_REVERSE_LSB = 1;
  localparam int CTRL_OUTPUT_BIT_REVERSE_BIT = 3;
  localparam int CTRL_BUSY_BIT = 4;
  localparam int GATE_CRC_BIT = 21;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [31:0] DATA_RESET = 32'hFFFFFFFF;
  localparam logic [31:0] SEED_RESET = 32'hFFFFFFFF;
  localparam logic [31:0] XOR_RESET = 32'h00000000;
  localparam logic [31:0] GATE_RESET = 32'h00000001;
  localparam logic [1:0] POLY_RESET = 2'h0;

  // ************************************************************
  // polynomials and widths
  // ************************************************************
  localparam logic [31:0] POLY_32 = 32'h04C11DB7;
  localparam logic [31:0] POLY_16 = 32'h00001021;
  localparam logic [31:0] POLY_8 = 32'h00000007;
  localparam logic [1:0] SEL_32 = 2'h0;
  localparam logic [1:0] SEL_16 = 2'h1;
  localparam logic [1:0] SEL_8 = 2'h2;
  localparam logic [4:0] ALIGN_32 = 5'h00;
  localparam logic [4:0] ALIGN_16 = 5'h10;
  localparam logic [4:0] ALIGN_8 = 5'h18;
  localparam logic [31:0] MASK_32 = 32'hFFFFFFFF;
  localparam logic [31:0] MASK_16 = 32'h0000FFFF;
  localparam logic [31:0] MASK_8 = 32'h000000FF;

  // ************************************************************
  // data sizes and step cycles
  // ************************************************************
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [2:0] CYCLES_WORD = 3'h4;
  localparam logic [2:0] CYCLES_HALF = 3'h2;
  localparam logic [2:0] CYCLES_BYTE = 3'h1;

  // ************************************************************
  // bus answers and buffer
  // ************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 34;

endpackage

// ===== core/crc_fifo.sv
`timescale 1ns/100ps
`default_nettype none

module crc_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 16
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic flush_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
  } fifo_state_s;

  fifo_state_s s;
  fifo_state_s next_s;
  logic push;
  logic pop;

  assign in_ready_o = (s.count != (PW+1)'(DEPTH));
  assign out_valid_o = (s.count != '0);
  assign out_data_o = s.mem[s.rd_ptr];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wr_ptr] = in_data_i;
      next_s.wr_ptr = s.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_s.rd_ptr = s.rd_ptr + 1'b1;
    end
    next_s.count = s.count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    if (flush_i) begin
      next_s.wr_ptr = '0;
      next_s.rd_ptr = '0;
      next_s.count = '0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

`default_nettype wire

// ===== core/crc_calc_unit.sv
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - polynomials 04C11DB7 default, 1021, 07
// - word 4, halfword 2, byte 1 cycles
// - each data write with gate bit 21 set folds into running crc
// - data read returns current result
// - reads seed before data, resets all ones
// - narrow polynomial or size uses low bits
// - write width selects byte, halfword, word
// - input reversal by code and size
// - output reversal by polynomial width
// - gate bit 21 enables unit, resets 0
// - programmable seed and final xor value
// - select 00 32-bit, 01 16, 10 8
// - busy while calculating, software waits
// - reset bit pulses one cycle, self clears
module crc_calc_unit (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [crc_pkg::ADDR_W-1:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [crc_pkg::ADDR_W-1:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i
);
  import crc_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_held;
    logic [ADDR_W-1:0] waddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] crc;
    logic output_bit_reverse;
    logic [1:0] input_bit_reverse;
    logic soft_reset;
    logic [1:0] poly_choice_field;
    logic [31:0] seed;
    logic [31:0] out_mask;
    logic [31:0] clock_gate;
    logic [2:0] step_count;
    logic [31:0] step_data;
  } unit_state_s;

  unit_state_s s;
  unit_state_s next_s;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] rev_group(input logic [31:0] v, input int gw);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < 32; i++) begin
      r[i] = v[(i / gw) * gw + gw - 1 - (i % gw)];
    end
    return r;
  endfunction

  function automatic logic [31:0] width_mask(input logic [1:0] sel);
    logic [31:0] m;
    unique case (sel)
      SEL_16: m = MASK_16;
      SEL_8: m = MASK_8;
      default: m = MASK_32;
    endcase
    return m;
  endfunction

  // one byte through the selected generator, msb first, crc kept right aligned
  function automatic logic [31:0] crc_byte(input logic [31:0] crc, input logic [7:0] b,
                                           input logic [1:0] sel);
    logic [31:0] a;
    logic [31:0] p;
    logic [4:0] sh;
    unique case (sel)
      SEL_16: begin
        sh = ALIGN_16;
        p = POLY_16;
      end
      SEL_8: begin
        sh = ALIGN_8;
        p = POLY_8;
      end
      default: begin
        sh = ALIGN_32;
        p = POLY_32;
      end
    endcase
    p = p << sh;
    a = (crc << sh) ^ {b, 24'h000000};
    for (int i = 0; i < 8; i++) begin
      a = a[31] ? ((a << 1) ^ p) : (a << 1);
    end
    return a >> sh;
  endfunction

  // input reversal, then first byte moved to the top
  function automatic logic [31:0] load_data(input logic [31:0] d, input logic [1:0] size,
                                            input logic [1:0] code);
    logic [31:0] r;
    int gw;
    gw = 8;
    if (code == 2'h2 && size != SIZE_BYTE) begin
      gw = 16;
    end
    if (code == 2'h3) begin
      gw = (size == SIZE_WORD) ? 32 : ((size == SIZE_HALF) ? 16 : 8);
    end
    r = (code == 2'h0) ? d : rev_group(d, gw);
    unique case (size)
      SIZE_HALF: r = {r[15:0], 16'h0000};
      SIZE_BYTE: r = {r[7:0], 24'h000000};
      default: r = r;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] result(input unit_state_s st);
    logic [31:0] r;
    r = st.crc;
    if (st.output_bit_reverse) begin
      unique case (st.poly_choice_field)
        SEL_16: r = rev_group(st.crc, 16);
        SEL_8: r = rev_group(st.crc, 8);
        default: r = rev_group(st.crc, 32);
      endcase
    end
    return (r ^ st.out_mask) & width_mask(st.poly_choice_field);
  endfunction

  // ************************************************************
  // buffer of data writes
  // ************************************************************
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [FIFO_WIDTH-1:0] fifo_in_data;
  logic [FIFO_WIDTH-1:0] fifo_out_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic wr_pending;
  logic wr_to_data;
  logic wr_commit;
  logic gate_on;
  logic busy;
  logic [1:0] wr_size;

  assign gate_on = s.clock_gate[GATE_CRC_BIT];
  assign wr_pending = s.aw_held & s.w_held & ~s.bvalid;
  assign wr_to_data = (s.waddr == OFS_DATA);
  assign wr_size = (s.wstrb[3] | s.wstrb[2]) ? SIZE_WORD :
                   (s.wstrb[1] ? SIZE_HALF : SIZE_BYTE);
  assign fifo_in_data = {wr_size, s.wdata};
  assign fifo_in_valid = wr_pending & wr_to_data & gate_on & ~s.soft_reset;
  assign wr_commit = wr_pending &
                     ~(wr_to_data & gate_on & (s.soft_reset | ~fifo_in_ready));
  assign fifo_out_ready = (s.step_count == 3'h0) & gate_on & ~s.soft_reset;
  assign busy = fifo_out_valid | (s.step_count != 3'h0);

  crc_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) data_fifo (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .flush_i(s.soft_reset),
    .in_data_i(fifo_in_data),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_out_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready)
  );

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic [31:0] first;
    first = '0;
    next_s = s;
    next_s.soft_reset = 1'b0;

    // write channels
    if (awvalid_i && s.awready) begin
      next_s.awready = 1'b0;
      next_s.aw_held = 1'b1;
      next_s.waddr = awaddr_i;
    end
    if (wvalid_i && s.wready) begin
      next_s.wready = 1'b0;
      next_s.w_held = 1'b1;
      next_s.wdata = wdata_i;
      next_s.wstrb = wstrb_i;
    end
    if (wr_commit) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      case (s.waddr)
        OFS_DATA: begin
          next_s.bresp = RESP_OKAY;
        end
        OFS_CTRL: begin
          if (s.wstrb[0]) begin
            next_s.soft_reset = s.wdata[CTRL_RESET_BIT];
            next_s.input_bit_reverse = s.wdata[CTRL_INPUT_BIT_REVERSE_LSB +: 2];
            next_s.output_bit_reverse = s.wdata[CTRL_OUTPUT_BIT_REVERSE_BIT];
          end
        end
        OFS_POLY: begin
          if (s.wstrb[0]) begin
            next_s.poly_choice_field = s.wdata[1:0];
          end
        end
        OFS_SEED: begin
          next_s.seed = merge(s.seed, s.wdata, s.wstrb);
        end
        OFS_XOR: begin
          next_s.out_mask = merge(s.out_mask, s.wdata, s.wstrb);
        end
        OFS_GATE: begin
          next_s.clock_gate = merge(s.clock_gate, s.wdata, s.wstrb);
        end
        default: begin
          next_s.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (s.bvalid && bready_i) begin
      next_s.bvalid = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end

    // read channels
    if (arvalid_i && s.arready) begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      case (araddr_i)
        OFS_DATA: next_s.rdata = result(s);
        OFS_CTRL: begin
          next_s.rdata = '0;
          next_s.rdata[CTRL_RESET_BIT] = s.soft_reset;
          next_s.rdata[CTRL_INPUT_BIT_REVERSE_LSB +: 2] = s.input_bit_reverse;
          next_s.rdata[CTRL_OUTPUT_BIT_REVERSE_BIT] = s.output_bit_reverse;
          next_s.rdata[CTRL_BUSY_BIT] = busy;
        end
        OFS_POLY: next_s.rdata = {30'h00000000, s.poly_choice_field};
        OFS_SEED: next_s.rdata = s.seed;
        OFS_XOR: next_s.rdata = s.out_mask;
        OFS_GATE: next_s.rdata = s.clock_gate;
        default: begin
          next_s.rdata = '0;
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (s.rvalid && rready_i) begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end

    // calculation engine, one byte per cycle
    if (s.soft_reset) begin
      next_s.crc = s.seed & width_mask(s.poly_choice_field);
      next_s.step_count = 3'h0;
    end else if (gate_on) begin
      if (s.step_count != 3'h0) begin
        next_s.crc = crc_byte(s.crc, s.step_data[31:24], s.poly_choice_field);
        next_s.step_data = s.step_data << 8;
        next_s.step_count = s.step_count - 3'h1;
      end else if (fifo_out_valid) begin
        first = load_data(fifo_out_data[31:0], fifo_out_data[33:32], s.input_bit_reverse);
        next_s.crc = crc_byte(s.crc, first[31:24], s.poly_choice_field);
        next_s.step_data = first << 8;
        unique case (fifo_out_data[33:32])
          SIZE_WORD: next_s.step_count = CYCLES_WORD - 3'h1;
          SIZE_HALF: next_s.step_count = CYCLES_HALF - 3'h1;
          default: next_s.step_count = CYCLES_BYTE - 3'h1;
        endcase
      end
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s <= '0;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.crc <= DATA_RESET;
      s.seed <= SEED_RESET;
      s.out_mask <= XOR_RESET;
      s.clock_gate <= GATE_RESET;
      s.poly_choice_field <= POLY_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign awready_o = s.awready;
  assign wready_o = s.wready;
  assign bvalid_o = s.bvalid;
  assign bresp_o = s.bresp;
  assign arready_o = s.arready;
  assign rvalid_o = s.rvalid;
  assign rresp_o = s.rresp;
  assign rdata_o = s.rdata;

endmodule

`default_nettype wire

// ===== sim/crc_calc_unit_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module crc_calc_unit_assertions (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [crc_pkg::ADDR_W-1:0] awaddr_i,
  input wire logic awvalid_i,
  input wire logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  input wire logic wready_o,
  input wire logic [1:0] bresp_o,
  input wire logic bvalid_o,
  input wire logic bready_i,
  input wire logic [crc_pkg::ADDR_W-1:0] araddr_i,
  input wire logic arvalid_i,
  input wire logic arready_o,
  input wire logic [31:0] rdata_o,
  input wire logic [1:0] rresp_o,
  input wire logic rvalid_o,
  input wire logic rready_i
);
  import crc_pkg::*;
  // ****************
  // helpers
  // ****************
  logic fresh;
  logic rd_map;
  logic wr_map;
  assign rd_map = araddr_i[1:0] == 2'h0 && araddr_i <= OFS_GATE;
  assign wr_map = awaddr_i[1:0] == 2'h0 && awaddr_i <= OFS_GATE;
  always_ff @(posedge clock_i) begin
    if (rst_i) fresh <= 1'b1;
    else if (awvalid_i && awready_o) fresh <= 1'b0;
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  sequence wr_taken;
    awvalid_i && awready_o && wvalid_i && wready_o;
  endsequence
  sequence rd_taken;
    arvalid_i && arready_o;
  endsequence
  sequence b_done;
    bvalid_o && bready_i;
  endsequence
  // ****************
  // assertions
  // ****************
  a_write_answered: assert property (wr_taken |-> ##[1:100] bvalid_o)
    else $error("write not answered");
  a_write_blocks: assert property (wr_taken |=> (!awready_o && !wready_o) until_with b_done)
    else $error("write channels reopened early");
  a_ready_returns: assert property (b_done |=> awready_o && wready_o && !bvalid_o)
    else $error("write channels not reopened");
  a_cfg_write_ok: assert property ((wr_taken and (wr_map && awaddr_i != OFS_DATA)) |->
    ##2 (bvalid_o && bresp_o == RESP_OKAY))
    else $error("config write answer wrong");
  a_bad_write: assert property ((wr_taken and !wr_map) |->
    ##2 (bvalid_o && bresp_o == RESP_SLVERR))
    else $error("unmapped write not refused");
  a_read_latency: assert property ((rd_taken and rd_map) |=>
    (rvalid_o && rresp_o == RESP_OKAY))
    else $error("read answer late or wrong");
  a_bad_read: assert property ((rd_taken and !rd_map) |=>
    (rvalid_o && rresp_o == RESP_SLVERR && rdata_o == 32'h0))
    else $error("unmapped read not refused");
  a_seed_first: assert property ((rd_taken and (fresh && araddr_i == OFS_DATA)) |=>
    (rdata_o == DATA_RESET))
    else $error("data read after reset wrong");
endmodule
bind crc_calc_unit crc_calc_unit_assertions u_chk (
  .clock_i(clock_i), .rst_i(rst_i), .awaddr_i(awaddr_i), .awvalid_i(awvalid_i),
  .awready_o(awready_o), .wdata_i(wdata_i), .wstrb_i(wstrb_i), .wvalid_i(wvalid_i),
  .wready_o(wready_o), .bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready_i),
  .araddr_i(araddr_i), .arvalid_i(arvalid_i), .arready_o(arready_o), .rdata_o(rdata_o),
  .rresp_o(rresp_o), .rvalid_o(rvalid_o), .rready_i(rready_i)
);
`default_nettype wire

// ===== sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import crc_pkg::*;
  logic clock_i, rst_i, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, got, seed, xorv, crc, p;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, lresp;
  int mismatches, comparisons, cycles, w;
  crc_calc_unit u_dut (
    .clock_i(clock_i), .rst_i(rst_i), .awaddr_i(awaddr), .awvalid_i(awvalid),
    .awready_o(awready), .wdata_i(wdata), .wstrb_i(wstrb), .wvalid_i(wvalid),
    .wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid), .bready_i(bready),
    .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready), .rdata_o(rdata),
    .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready)
  );
  always #20 clock_i = ~clock_i;
  // ****************
  // bus tasks and reference
  // ****************
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clock_i);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    lresp = bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    lresp = rresp;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      rd(OFS_CTRL, got);
      n++;
    end while (got[4] !== 1'b0 && n < 8);
    check("idle polls", 32'(n <= 2), 32'h1);
  endtask
  function automatic logic [31:0] rev_blk(input logic [31:0] x, input int blk);
    logic [31:0] r;
    for (int i = 0; i < 32; i++) r[i] = x[(i / blk) * blk + blk - 1 - i % blk];
    return r;
  endfunction
  function automatic logic [31:0] fold(input logic [31:0] c, input logic [31:0] d,
                                       input int sz, input int code);
    if (code != 0) d = rev_blk(d, 8 << ((code - 1 < sz) ? code - 1 : sz));
    for (int b = (1 << sz) - 1; b >= 0; b--) begin
      c = c ^ ({24'h0, d[8 * b +: 8]} << (w - 8));
      for (int k = 0; k < 8; k++) c = c[w - 1] ? ((c << 1) ^ p) : (c << 1);
    end
    return c & (MASK_32 >> (32 - w));
  endfunction
  function automatic logic [31:0] shown(input logic [31:0] c, input int ro);
    return ((ro != 0 ? rev_blk(c, w) : c) ^ xorv) & (MASK_32 >> (32 - w));
  endfunction
  task automatic final_report();
    if (mismatches == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 10000) begin
      mismatches++;
      final_report();
    end
  end
  // ****************
  // main sequence
  // ****************
  initial begin
    clock_i = 1'b0;
    rst_i = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
    {mismatches, comparisons, cycles} = '0;
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(OFS_DATA, got);
    check("data reset", got, DATA_RESET);
    rd(OFS_GATE, got);
    check("gate reset", got, GATE_RESET);
    rd(OFS_SEED, got);
    check("seed reset", got, SEED_RESET);
    wr(OFS_DATA, 32'h000000A5, 4'hF);
    rd(OFS_DATA, got);
    check("gated data", got, DATA_RESET);
    wr(8'h18, 32'h1, 4'hF);
    check("bad write", {30'h0, lresp}, {30'h0, RESP_SLVERR});
    rd(8'h18, got);
    check("bad read", {got[29:0], lresp}, {30'h0, RESP_SLVERR});
    wr(OFS_GATE, 32'h00200001, 4'hF);
    rd(OFS_GATE, got);
    check("gate on", got, 32'h00200001);
    for (int sel = 0; sel < 3; sel++) begin
      w = 32 >> sel;
      p = sel == 0 ? POLY_32 : sel == 1 ? POLY_16 : POLY_8;
      for (int code = 0; code < 4; code++) begin
        for (int ro = 0; ro < 2; ro++) begin
          seed = 32'hC0DE1234 + 32'(code);
          xorv = ro != 0 ? 32'h5AA5F00F : 32'h0;
          wr(OFS_POLY, 32'(sel), 4'h1);
          wr(OFS_SEED, seed, 4'hF);
          wr(OFS_XOR, xorv, 4'hF);
          wr(OFS_CTRL, 32'(ro * 8 + code * 2 + 1), 4'h1);
          crc = seed & (MASK_32 >> (32 - w));
          rd(OFS_DATA, got);
          check("seed read", got, shown(crc, ro));
          wr(OFS_DATA, 32'h1A2B3C4D, 4'hF);
          crc = fold(crc, 32'h1A2B3C4D, 2, code);
          rd(OFS_CTRL, got);
          check("busy", {31'h0, got[4]}, 32'h1);
          wait_idle();
          wr(OFS_DATA, 32'hFFFF8E71, 4'h3);
          crc = fold(crc, 32'hFFFF8E71, 1, code);
          wait_idle();
          wr(OFS_DATA, 32'hFFFFFF96, 4'h1);
          crc = fold(crc, 32'hFFFFFF96, 0, code);
          wait_idle();
          check("ctrl", got, 32'(ro * 8 + code * 2));
          rd(OFS_DATA, got);
          check("result", got, shown(crc, ro));
        end
      end
    end
    wr(OFS_GATE, GATE_RESET, 4'hF);
    wr(OFS_DATA, 32'h00000077, 4'h1);
    rd(OFS_DATA, got);
    check("held crc", got, shown(crc, 1));
    wr(OFS_POLY, 32'h00000003, 4'h1);
    rd(OFS_POLY, got);
    check("poly code 3", got, 32'h00000003);
    final_report();
  end
endmodule
`default_nettype wire
